// ===== src/flash_host_pkg.sv
/*
 * Shared constants and types of the flash protection host controller:
 * register offsets, operation codes, command bytes, bus timing and the
 * structs that carry one flash bus cycle and the flash pin outputs.
 * Assumes a 100 MHz system clock and a 22-bit address, 16-bit flash bus.
 */
package flash_host_pkg;

    // Register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] REG_CTRL = 8'h00;   // Operation code, write starts
    localparam logic [7:0] REG_ADDR = 8'h04;   // Flash address operand
    localparam logic [7:0] REG_DATA = 8'h08;   // Flash data operand
    localparam logic [7:0] REG_STAT = 8'h0c;   // Busy and ready pin state
    localparam logic [7:0] REG_RDAT = 8'h10;   // Last word read from flash
    localparam logic [7:0] REG_RST = 8'h14;    // Flash hardware reset control

    // Field positions and reset values
    localparam int STAT_BUSY = 0;              // Operation in progress
    localparam int STAT_READY = 1;             // Filtered ready/busy pin
    localparam int RST_HOLD = 0;               // 1 holds flash in reset
    localparam logic RST_HOLD_INIT = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operations that software may start
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_RESET = 4'h1, OP_SUSPEND = 4'h2,
        OP_RESUME = 4'h3, OP_PWD_PROG = 4'h4, OP_PWD_VERIFY = 4'h5,
        OP_PWD_UNLOCK = 4'h6, OP_VOL_WRITE = 4'h7, OP_LOCK_SET = 4'h8,
        OP_MODE_PWD = 4'h9, OP_MODE_PERS = 4'ha, OP_SECT_PROT = 4'hb
    } op_t;
    localparam logic [3:0] OP_LAST = 4'hb;

    // Command bytes on the flash data pins
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_PWD_PROG = 8'h38;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [21:0] ADDR_UNLOCK1 = 22'h000555;
    localparam logic [21:0] ADDR_UNLOCK2 = 22'h0002aa;

    // Bus timing in ns and derived 100 MHz cycle counts (least: round up)
    localparam int CLK_NS = 10;
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 50;
    localparam int READ_NS = 120;
    localparam int GAP_NS = 30;
    localparam int SETTLE_NS = 60;             // Lets the pin filter see busy
    localparam int UNLOCK_NS = 2000;           // Per password unlock portion
    localparam int SUSPEND_NS = 20000;         // Longest suspend latency
    localparam logic [11:0] SETUP_CYC = 12'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] STROBE_CYC = 12'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] READ_CYC = 12'((READ_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] GAP_CYC = 12'((GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SETTLE_CYC = 12'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] UNLOCK_CYC = 12'((UNLOCK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SUSPEND_CYC = 12'((SUSPEND_NS + CLK_NS - 1) / CLK_NS);

    // One flash bus cycle of a command sequence
    typedef struct packed {
        logic last;                            // Final cycle of the sequence
        logic rd;                              // Read cycle, else write
        logic [21:0] addr;
        logic [15:0] data;
    } cycle_t;

    // Flash pins driven by the controller
    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] dq;
        logic dq_oe;                           // High while driving data pins
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
    } pins_t;

endpackage

// ===== src/flash_host.sv
/*
 * Host controller for a banked NOR flash: runs erase suspend/resume and the
 * protection command sequences on the flash pins on software's order.
 * Assumes an AXI4-Lite master on the register side and a flash whose
 * ready/busy and data pins are asynchronous to clock_i.
 */
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module flash_host #(
    parameter int ADDR_W = 22,                 // Flash address width
    parameter int DATA_W = 16                  // Flash data width
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // AXI4-Lite write address and data
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // AXI4-Lite write response
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // AXI4-Lite read
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [7:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // Flash pins
    output flash_host_pkg::pins_t flash_o,
    input wire logic [15:0] flash_dq_i,
    input wire logic ready_busy_n_i
);
    import flash_host_pkg::*;

    initial begin
        if (ADDR_W != 22 || DATA_W != 16) begin
            $error("flash_host supports only a 22-bit by 16-bit flash bus");
        end
    end

    // Engine states, one-hot
    typedef enum logic [4:0] {
        S_IDLE = 5'h01, S_SETUP = 5'h02, S_STROBE = 5'h04,
        S_HOLD = 5'h08, S_WAIT = 5'h10
    } state_t;

    // Builds cycle idx of operation op from the operands
    function automatic cycle_t step_of(input op_t op, input logic [2:0] idx,
                                       input logic [21:0] a,
                                       input logic [15:0] d);
        logic [21:0] bank;
        cycle_t c;
        bank = {a[21:19], 19'h0};
        c = '{last: 1'b0, rd: 1'b0, addr: ADDR_UNLOCK1,
              data: {8'h00, CMD_UNLOCK1}};
        if (idx == 3'h1) begin
            c.addr = ADDR_UNLOCK2;
            c.data = {8'h00, CMD_UNLOCK2};
        end else if (idx == 3'h2) begin
            c.addr = bank | ADDR_UNLOCK1;
            c.data = {8'h00, cmd_of(op)};
        end else if (idx != 3'h0) begin
            c = '{last: 1'b1, rd: 1'b0, addr: a, data: d};
        end
        case (op)
            OP_READ: c = '{last: 1'b1, rd: 1'b1, addr: a, data: 16'h0000};
            OP_RESET: c = '{last: 1'b1, rd: 1'b0, addr: a,
                            data: {8'h00, CMD_RESET}};
            OP_SUSPEND: c = '{last: 1'b1, rd: 1'b0, addr: bank,
                              data: {8'h00, CMD_SUSPEND}};
            OP_RESUME: c = '{last: 1'b1, rd: 1'b0, addr: bank,
                             data: {8'h00, CMD_RESUME}};
            OP_PWD_VERIFY: begin
                // Only the two low bits choose the portion
                if (idx == 3'h3) begin
                    c = '{last: 1'b1, rd: 1'b1, addr: {20'h0, a[1:0]},
                          data: 16'h0000};
                end
            end
            OP_VOL_WRITE: begin
                // Sector bits only, data reduced to 01h or 00h
                if (idx == 3'h3) begin
                    c.addr = {a[21:12], 12'h000};
                    c.data = {15'h0000, d[0]};
                end
            end
            default: begin
            end
        endcase
        return c;
    endfunction

    // Command byte written in the third cycle of an unlocked sequence
    function automatic logic [7:0] cmd_of(input op_t op);
        case (op)
            OP_PWD_PROG: return CMD_PWD_PROG;
            OP_PWD_VERIFY: return 8'hc8;
            OP_PWD_UNLOCK: return 8'h28;
            OP_VOL_WRITE: return 8'h48;
            OP_LOCK_SET: return 8'h78;
            OP_MODE_PWD: return 8'h68;
            OP_MODE_PERS: return 8'h58;
            OP_SECT_PROT: return 8'h88;
            default: return CMD_RESET;
        endcase
    endfunction

    // Least wait after the last cycle before ready is trusted
    function automatic logic [11:0] wait_of(input op_t op);
        case (op)
            OP_SUSPEND: return SUSPEND_CYC;
            OP_PWD_UNLOCK: return UNLOCK_CYC;
            OP_READ, OP_RESET, OP_RESUME, OP_PWD_VERIFY: return 12'h001;
            default: return SETTLE_CYC;
        endcase
    endfunction

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Register state
    logic [21:0] addr_q;                       // Address operand
    logic [15:0] data_q;                       // Data operand
    logic [15:0] rdat_q;                       // Last flash read
    logic rst_hold_q;                          // Software flash reset
    op_t op_q;                                 // Operation under way
    logic start_q;                             // One-cycle start pulse
    logic busy_q;                              // Engine not idle
    // AXI slave state
    logic aw_have_q, w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    // Engine state
    state_t st_q;
    logic [2:0] idx_q;                         // Cycle index in sequence
    logic [11:0] cnt_q;                        // Phase countdown
    cycle_t cur_q;                             // Cycle being driven
    pins_t pins_q;
    // Pin filters: three flops, change taken when last two agree
    logic [2:0] rb_s_q;
    logic rb_q;
    logic [15:0] dq_s1_q, dq_s2_q, dq_s3_q;

    assign flash_o = pins_q;

    // Pin input filters
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rb_s_q <= 3'h0;
            rb_q <= 1'b0;
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
            dq_s3_q <= 16'h0000;
        end else begin
            rb_s_q <= {rb_s_q[1:0], ready_busy_n_i};
            if (rb_s_q[1] == rb_s_q[2]) begin
                rb_q <= rb_s_q[2];
            end
            dq_s1_q <= flash_dq_i;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
        end
    end

    // AXI write side: holds address and data until both are in
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            // Ready outputs kept in flops of their own
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
            addr_q <= 22'h0;
            data_q <= 16'h0000;
            rst_hold_q <= RST_HOLD_INIT;
            op_q <= OP_READ;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (s_axi_awvalid_i && !aw_have_q) begin
                aw_have_q <= 1'b1;
                s_axi_awready_o <= 1'b0;
                awaddr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && !w_have_q) begin
                w_have_q <= 1'b1;
                s_axi_wready_o <= 1'b0;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            if (aw_have_q && w_have_q && !s_axi_bvalid_o) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= RESP_OKAY;
                case (awaddr_q)
                    REG_ADDR: addr_q <= 22'(merge({10'h0, addr_q},
                                                   wdata_q, wstrb_q));
                    REG_DATA: data_q <= 16'(merge({16'h0, data_q},
                                                   wdata_q, wstrb_q));
                    REG_RST: rst_hold_q <= wstrb_q[0] ? wdata_q[RST_HOLD]
                                                       : rst_hold_q;
                    REG_CTRL: begin
                        // Refused while busy or for an unknown code
                        if (busy_q || start_q || wdata_q[3:0] > OP_LAST) begin
                            s_axi_bresp_o <= RESP_SLVERR;
                        end else begin
                            op_q <= op_t'(wdata_q[3:0]);
                            start_q <= 1'b1;
                        end
                    end
                    REG_STAT, REG_RDAT: begin
                    end
                    default: s_axi_bresp_o <= RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // AXI read side: answer one cycle after the address is taken
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_rvalid_o) begin
            if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= RESP_OKAY;
            case (s_axi_araddr_i)
                REG_CTRL: s_axi_rdata_o <= {28'h0, op_q};
                REG_ADDR: s_axi_rdata_o <= {10'h0, addr_q};
                REG_DATA: s_axi_rdata_o <= {16'h0, data_q};
                REG_STAT: s_axi_rdata_o <= {30'h0, rb_q, busy_q};
                REG_RDAT: s_axi_rdata_o <= {16'h0, rdat_q};
                REG_RST: s_axi_rdata_o <= {31'h0, rst_hold_q};
                default: begin
                    s_axi_rdata_o <= 32'h0;
                    s_axi_rresp_o <= RESP_SLVERR;
                end
            endcase
        end
    end

    // Sequence engine: setup, strobe, hold per cycle, then wait for ready
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= S_IDLE;
            idx_q <= 3'h0;
            cnt_q <= 12'h000;
            cur_q <= '0;
            busy_q <= 1'b0;
            rdat_q <= 16'h0000;
            pins_q <= '{addr: 22'h0, dq: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1,
                        oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0};
        end else begin
            // Held reset also clears volatile flash state
            pins_q.reset_n <= ~rst_hold_q;
            case (st_q)
                S_IDLE: begin
                    if (start_q) begin
                        cur_q <= step_of(op_q, 3'h0, addr_q, data_q);
                        idx_q <= 3'h0;
                        busy_q <= 1'b1;
                        st_q <= S_SETUP;
                        cnt_q <= SETUP_CYC;
                    end
                end
                S_SETUP: begin
                    // Address and data settle before the strobe
                    pins_q.addr <= cur_q.addr;
                    pins_q.dq <= cur_q.data;
                    pins_q.dq_oe <= ~cur_q.rd;
                    pins_q.ce_n <= 1'b0;
                    cnt_q <= cnt_q - 12'h001;
                    if (cnt_q == 12'h000) begin
                        pins_q.we_n <= cur_q.rd;
                        pins_q.oe_n <= ~cur_q.rd;
                        cnt_q <= cur_q.rd ? READ_CYC : STROBE_CYC;
                        st_q <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    if (cnt_q != 12'h000) begin
                        cnt_q <= cnt_q - 12'h001;
                    end else if (!cur_q.rd || dq_s2_q == dq_s3_q) begin
                        // Read data taken only once it is steady
                        if (cur_q.rd) begin
                            rdat_q <= dq_s3_q;
                        end
                        pins_q.we_n <= 1'b1;
                        pins_q.oe_n <= 1'b1;
                        cnt_q <= GAP_CYC;
                        st_q <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    cnt_q <= cnt_q - 12'h001;
                    if (cnt_q == 12'h000) begin
                        pins_q.ce_n <= 1'b1;
                        pins_q.dq_oe <= 1'b0;
                        if (cur_q.last) begin
                            cnt_q <= wait_of(op_q);
                            st_q <= S_WAIT;
                        end else begin
                            cur_q <= step_of(op_q, idx_q + 3'h1, addr_q,
                                             data_q);
                            idx_q <= idx_q + 3'h1;
                            cnt_q <= SETUP_CYC;
                            st_q <= S_SETUP;
                        end
                    end
                end
                S_WAIT: begin
                    // Next portion only after the least time and ready
                    if (cnt_q != 12'h000) begin
                        cnt_q <= cnt_q - 12'h001;
                    end else if (rb_q) begin
                        busy_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Cycles spent in the wait phase, for the checks below
    logic [11:0] wlen_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wlen_q <= 12'h000;
        end else if (st_q != S_WAIT) begin
            wlen_q <= 12'h000;
        end else if (wlen_q != 12'hfff) begin
            wlen_q <= wlen_q + 12'h001;
        end
    end

    no_double_strobe_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) !(!pins_q.we_n && !pins_q.oe_n))
        else $error("write and read strobes low together");
    suspend_code_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) (op_q == OP_SUSPEND && !pins_q.we_n) |->
        (pins_q.dq[7:0] == 8'hb0 && pins_q.addr[18:0] == 19'h0))
        else $error("suspend not B0h at bank address");
    resume_code_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) (op_q == OP_RESUME && !pins_q.we_n) |->
        (pins_q.dq[7:0] == 8'h30 && pins_q.addr[18:0] == 19'h0))
        else $error("resume not 30h at bank address");
    pwd_prog_cmd_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) (op_q == OP_PWD_PROG && idx_q == 3'h2 &&
        $fell(pins_q.we_n)) |-> pins_q.dq[7:0] == 8'h38 ##1 !pins_q.we_n)
        else $error("password program command byte wrong");
    vol_data_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) (op_q == OP_VOL_WRITE && idx_q == 3'h3 &&
        !pins_q.we_n) |-> (pins_q.dq[15:1] == 15'h0 &&
        pins_q.addr[11:0] == 12'h0))
        else $error("volatile bit write not 01h/00h at sector");
    unlock_space_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) (op_q == OP_PWD_UNLOCK && st_q == S_WAIT)
        ##1 (st_q == S_IDLE) |-> (wlen_q > 12'd200 && $past(rb_q)))
        else $error("unlock portion ended before 2 us and ready");
    suspend_wait_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) $fell(busy_q) && op_q == OP_SUSPEND |->
        wlen_q > 12'd2000)
        else $error("suspend wait shorter than 20 us");
    verify_addr_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) (op_q == OP_PWD_VERIFY && !pins_q.oe_n) |->
        (pins_q.addr[21:2] == 20'h0 && !pins_q.dq_oe))
        else $error("verify read with high address bits set");
    we_framed_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) $fell(pins_q.we_n) |->
        (!pins_q.ce_n && pins_q.dq_oe) [*5])
        else $error("write strobe without select and data drive");

endmodule

// ===== test/flash_dev_model.sv
/* Behavioural flash for the host bench: password store, verify, mode lock
   and busy pulses. Assumes it sees the host's pins_t outputs directly. */
`timescale 1ns/1ps
module flash_dev_model (
    // Pins from the host
    input wire flash_host_pkg::pins_t pins_i,
    // Pins back to the host, and last write seen
    output logic [15:0] dq_o,
    output logic ready_busy_n_o,
    output logic [7:0] last_cmd_o,
    output logic [21:0] last_addr_o
);
    logic [15:0] pwd [4] = '{default: 16'hffff}; // Factory all ones
    logic [7:0] prev_q = 8'h00;               // Previous command byte
    logic verify_q = 1'b0;
    logic lock_q = 1'b0;
    logic pers_q = 1'b0;                      // Persistent mode locked
    logic [15:0] val;
    initial ready_busy_n_o = 1'b1;
    // Verify shows password by A1-A0, all ones once locked
    // Otherwise status, not array data, as during password programming
    assign val = !verify_q ? 16'h0080 :
        lock_q ? 16'hffff : pwd[pins_i.addr[1:0]];
    // Released bus shows the inverse, never a stale value
    assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? val : ~val;
    // Write cycles latch on the rising write strobe
    always @(posedge pins_i.we_n) begin
        if (!pins_i.ce_n && pins_i.reset_n) begin
            last_cmd_o <= pins_i.dq[7:0];
            last_addr_o <= pins_i.addr;
            if (prev_q == 8'h38) // Program only clears bits
                pwd[pins_i.addr[1:0]] <= pwd[pins_i.addr[1:0]] & pins_i.dq;
            if (prev_q == 8'h68 && !pers_q) // One-time
                lock_q <= 1'b1;
            if (prev_q == 8'h58 && !lock_q) // Barred in password mode
                pers_q <= 1'b1;
            if (pins_i.dq[7:0] == 8'hc8)
                verify_q <= 1'b1;
            if (pins_i.dq[7:0] == 8'hf0) // Read/reset ends verify
                verify_q <= 1'b0;
            prev_q <= pins_i.dq[7:0];
            ready_busy_n_o <= 1'b0; // Busy after each write
            ready_busy_n_o <= #300 1'b1;
        end
    end
endmodule

// ===== test/test_flash_host.sv
/* Bench for flash_host: AXI4-Lite tasks run operations against a
   behavioural flash. Assumes flash_dev_model and flash_host_pkg. */
`timescale 1ns/1ps
module test_flash_host;
    import flash_host_pkg::*;
    logic clock_i = 0, rst_n_i = 0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0] awa = 0, ara = 0, lc;
    logic [31:0] wd = 0, rd;
    logic awr, wrdy, bv, arr, rv, rb;
    logic [1:0] bresp, rresp;
    logic [15:0] dq;
    logic [21:0] la;
    pins_t pins;
    int n_errors = 0, num_checks = 0;
    always #5 clock_i = ~clock_i; // 100 MHz
    flash_host dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .flash_o(pins),
        .flash_dq_i(dq), .ready_busy_n_i(rb));
    flash_dev_model flash (.pins_i(pins), .dq_o(dq), .ready_busy_n_o(rb),
        .last_cmd_o(lc), .last_addr_o(la));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Handshakes seen at the falling edge hold at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ta, tw, tb;
        tb = 0;
        @(posedge clock_i);
        {awv, wv, br} <= 3'h7;
        awa <= a;
        wd <= d;
        while (!tb) begin
            @(negedge clock_i);
            ta = awv & awr;
            tw = wv & wrdy;
            tb = bv;
            r = bresp;
            @(posedge clock_i);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        br <= 0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        logic ta, tr;
        tr = 0;
        @(posedge clock_i);
        {arv, rr} <= 2'h3;
        ara <= a;
        while (!tr) begin
            @(negedge clock_i);
            ta = arv & arr;
            tr = rv;
            d = rd;
            r = rresp;
            @(posedge clock_i);
            if (ta) arv <= 0;
        end
        rr <= 0;
    endtask
    // One operation: operands, start, then poll busy until clear
    task automatic op(input logic [3:0] c, input logic [21:0] a,
                      input logic [15:0] d);
        logic [31:0] s;
        logic [1:0] r;
        int n;
        wr(REG_ADDR, {10'h0, a}, r);
        wr(REG_DATA, {16'h0, d}, r);
        wr(REG_CTRL, {28'h0, c}, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        s = 1;
        for (n = 0; n < 1000 && s[STAT_BUSY]; n++) rdr(REG_STAT, s, r);
        chk({31'h0, s[STAT_BUSY]}, 32'h0);
        chk({31'h0, s[STAT_READY]}, 32'h1);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog well beyond the suspend wait and the rest
    initial begin
        #400000;
        n_errors++;
        conclude();
    end
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        time t;
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1;
        repeat (8) @(posedge clock_i);
        rdr(REG_RST, v, r);
        chk(v, {31'h0, RST_HOLD_INIT});
        rdr(8'h18, v, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(REG_CTRL, 32'hc, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test registers done");
        op(OP_PWD_PROG, 22'h1, 16'h1234);
        op(OP_PWD_VERIFY, 22'h380001, 16'h0);
        rdr(REG_RDAT, v, r);
        chk(v, 32'h1234);
        op(OP_PWD_PROG, 22'h1, 16'hffff);
        op(OP_PWD_VERIFY, 22'h1, 16'h0);
        rdr(REG_RDAT, v, r);
        chk(v, 32'h1234);
        t = $time;
        op(OP_PWD_UNLOCK, 22'h1, 16'h1234);
        chk({31'h0, ($time - t) >= 2000}, 32'h1);
        $display("test password done");
        op(OP_SUSPEND, 22'h2abcde, 16'h0);
        chk({lc, 2'h0, la}, {CMD_SUSPEND, 2'h0, 3'h5, 19'h0});
        op(OP_RESUME, 22'h2abcde, 16'h0);
        chk({lc, 2'h0, la}, {CMD_RESUME, 2'h0, 3'h5, 19'h0});
        op(OP_VOL_WRITE, 22'h12345, 16'hff01);
        chk({lc, 2'h0, la}, {8'h01, 12'h012, 12'h0});
        rdr(REG_ADDR, v, r);
        chk(v, 32'h12345);
        $display("test suspend and volatile done");
        op(OP_MODE_PWD, 22'h0, 16'h0);
        op(OP_PWD_VERIFY, 22'h1, 16'h0);
        rdr(REG_RDAT, v, r);
        chk(v, 32'hffff);
        op(OP_RESET, 22'h0, 16'h0);
        chk({24'h0, lc}, {24'h0, CMD_RESET});
        op(OP_READ, 22'h100, 16'h0);
        rdr(REG_RDAT, v, r);
        chk(v, 32'h0080);
        $display("test mode lock done");
        conclude();
    end
endmodule
